// file: rtl/cbc_branch_ctrl.sv
// decode and execute control for compare-branch, if-then and table branch
//
// Overview of operation
// - compare_zero_branch jumps when the register is zero; flags untouched
// - compare_nonzero_branch jumps when the register is nonzero; flags untouched
// - if_then_prefix predicates one to four following instructions
// - first uses base condition; later ones base or inverse per switch
// - breakpoint inside a block runs even when its condition fails
// - exceptions allowed in a block; state saved via link and status word
// - exception return restores block state and remaining conditions
// - if_then_prefix leaves the flags unchanged
// - byte table: fetch byte at base plus index, branch forward twice it
// - half table: index shifted by one, branch forward twice the entry
// - program counter as base means table starts after the instruction
`timescale 1ns/1ns
module cbc_branch_ctrl
    import cbc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // instruction stream
    input  wire cbc_instr_s  instr,
    output logic             instr_ready,
    // register file
    output logic [3:0]       rf_addr_a,
    output logic [3:0]       rf_addr_b,
    input  wire logic [31:0] rf_data_a,
    input  wire logic [31:0] rf_data_b,
    // flags
    input  wire cbc_flags_s  flags,
    // table read port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_half,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    // exception logic
    input  wire logic        exc_entry,
    output logic [7:0]       exc_it_state,
    input  wire logic        exc_return,
    input  wire logic [7:0]  exc_ret_it_state,
    // results
    output logic             branch_valid,
    output logic [31:0]      branch_target,
    output logic             exec_en,
    output logic             breakpoint_instr_hit,
    output logic             flags_hold
);
    typedef enum logic [1:0] { CBC_IDLE, CBC_TB_WAIT, CBC_TB_DONE } cbc_state_e;

    function automatic logic [31:0] fwd_target(input logic [31:0] from,
                                               input logic [31:0] half_units);
        fwd_target = from + {half_units[30:0], 1'b0};
    endfunction

    cbc_state_e  state_reg, state_next;
    cbc_it_s     it_reg, it_next;
    cbc_instr_s  hold_reg, hold_next;
    logic        req_reg, req_next;
    logic [31:0] maddr_reg, maddr_next;
    logic        mhalf_reg, mhalf_next;
    logic        br_reg, br_next;
    logic [31:0] tgt_reg, tgt_next;
    logic        ex_reg, ex_next;
    logic        bk_reg, bk_next;
    logic        fh_reg, fh_next;
    logic        rdy_reg, rdy_next;
    logic        in_block;
    logic [3:0]  slot_cond;
    logic        cond_pass;
    logic        take;
    logic [31:0] tb_base;
    logic [31:0] tb_index;

    assign in_block  = (it_reg.mask != 4'h0);
    // next switch bit sits in cond[0] position: mask[3] moves in per step
    assign slot_cond = in_block ? it_reg.cond : instr.cond;

    cbc_cond_eval u_cond (
        .cond  (slot_cond),
        .flags (flags),
        .pass  (cond_pass)
    );

    assign take        = instr.valid && (state_reg == CBC_IDLE);
    assign instr_ready = rdy_reg;
    assign rf_addr_a   = (state_reg == CBC_IDLE) ? instr.base_reg : hold_reg.base_reg;
    assign rf_addr_b   = (state_reg == CBC_IDLE) ? instr.index_reg : hold_reg.index_reg;
    assign tb_base     = (instr.base_reg == CBC_REG_PC) ?
                         instr.addr + CBC_TB_LEN : rf_data_a;
    assign tb_index    = (instr.op == CBC_OP_TB_HALF) ?
                         {rf_data_b[30:0], 1'b0} : rf_data_b;

    // ------------------------------------------------------------
    // execution control
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        it_next    = it_reg;
        hold_next  = hold_reg;
        req_next   = 1'b0;
        maddr_next = maddr_reg;
        mhalf_next = mhalf_reg;
        br_next    = 1'b0;
        tgt_next   = tgt_reg;
        ex_next    = 1'b0;
        bk_next    = 1'b0;
        fh_next    = 1'b0;
        unique case (state_reg)
            CBC_IDLE: begin
                if (exc_return) begin
                    it_next = exc_ret_it_state;
                end else if (take) begin
                    if (in_block) begin
                        // shift mask; low cond bit follows next switch
                        if (it_reg.mask[2:0] == 3'h0) begin
                            it_next = '0;
                        end else begin
                            it_next.cond = {it_reg.cond[3:1], it_reg.mask[3]};
                            it_next.mask = {it_reg.mask[2:0], 1'b0};
                        end
                    end
                    ex_next = cond_pass;
                    fh_next = 1'b1;
                    unique case (instr.op)
                        CBC_OP_CMP_ZERO: begin
                            br_next  = (rf_data_a == CBC_ZERO);
                            tgt_next = fwd_target(instr.addr + CBC_PC_AHEAD,
                                                  {25'h0, instr.offset});
                        end
                        CBC_OP_CMP_NONZERO: begin
                            br_next  = (rf_data_a != CBC_ZERO);
                            tgt_next = fwd_target(instr.addr + CBC_PC_AHEAD,
                                                  {25'h0, instr.offset});
                        end
                        CBC_OP_IT: begin
                            // flags only read, never written; prefix itself always runs
                            ex_next      = 1'b1;
                            it_next.cond = instr.cond;
                            it_next.mask = instr.it_mask;
                        end
                        CBC_OP_TB_BYTE, CBC_OP_TB_HALF: begin
                            if (cond_pass) begin
                                hold_next  = instr;
                                req_next   = 1'b1;
                                maddr_next = tb_base + tb_index;
                                mhalf_next = (instr.op == CBC_OP_TB_HALF);
                                state_next = CBC_TB_WAIT;
                            end
                        end
                        CBC_OP_BREAKPOINT_INSTR: begin
                            ex_next = 1'b1;
                            bk_next = 1'b1;
                        end
                        default: fh_next = 1'b0;
                    endcase
                end
            end
            CBC_TB_WAIT: begin
                req_next = ~mem_ack;
                if (mem_ack) begin
                    state_next = CBC_TB_DONE;
                    tgt_next   = fwd_target(hold_reg.addr + CBC_TB_LEN,
                                 mhalf_reg ? {16'h0, mem_rdata} :
                                             {24'h0, mem_rdata[7:0]});
                end
            end
            CBC_TB_DONE: begin
                br_next    = 1'b1;
                ex_next    = 1'b1;
                fh_next    = 1'b1;
                state_next = CBC_IDLE;
            end
            default: state_next = CBC_IDLE;
        endcase
        rdy_next = (state_next == CBC_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= CBC_IDLE;
            it_reg    <= '0;
            hold_reg  <= '0;
            req_reg   <= 1'b0;
            maddr_reg <= 32'h0;
            mhalf_reg <= 1'b0;
            br_reg    <= 1'b0;
            tgt_reg   <= 32'h0;
            ex_reg    <= 1'b0;
            bk_reg    <= 1'b0;
            fh_reg    <= 1'b0;
            rdy_reg   <= 1'b1;
        end else begin
            state_reg <= state_next;
            it_reg    <= it_next;
            hold_reg  <= hold_next;
            req_reg   <= req_next;
            maddr_reg <= maddr_next;
            mhalf_reg <= mhalf_next;
            br_reg    <= br_next;
            tgt_reg   <= tgt_next;
            ex_reg    <= ex_next;
            bk_reg    <= bk_next;
            fh_reg    <= fh_next;
            rdy_reg   <= rdy_next;
        end
    end

    // exception entry sees current state for stacking
    assign exc_it_state  = it_reg;
    assign mem_req       = req_reg;
    assign mem_addr      = maddr_reg;
    assign mem_half      = mhalf_reg;
    assign branch_valid  = br_reg;
    assign branch_target = tgt_reg;
    assign exec_en       = ex_reg;
    assign breakpoint_instr_hit      = bk_reg;
    assign flags_hold    = fh_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_cz_zero;
        take && !exc_return && instr.op == CBC_OP_CMP_ZERO && rf_data_a == CBC_ZERO;
    endsequence
    cz_branch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_cz_zero |=> branch_valid && flags_hold)
        else $error("zero compare branch not taken");
    cnz_branch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == CBC_OP_CMP_NONZERO && !exc_return |=>
        branch_valid == ($past(rf_data_a) != CBC_ZERO))
        else $error("nonzero compare branch wrong");
    it_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && !exc_return && instr.op == CBC_OP_IT |=> exc_it_state[3:0] == $past(instr.it_mask))
        else $error("if-then state not loaded");
    breakpoint_instr_exec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && !exc_return && instr.op == CBC_OP_BREAKPOINT_INSTR |=> exec_en && breakpoint_instr_hit)
        else $error("breakpoint not executed");
    exc_ret_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exc_return && state_reg == CBC_IDLE |=> exc_it_state == $past(exc_ret_it_state))
        else $error("block state not restored");
    exc_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        exc_entry && !instr.valid && !exc_return |=> exc_it_state == $past(exc_it_state))
        else $error("block state lost on exception entry");
    it_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && instr.op == CBC_OP_IT && !exc_return |=> flags_hold && !branch_valid)
        else $error("prefix disturbed flags");
    tb_req_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && !exc_return && instr.op == CBC_OP_TB_BYTE && cond_pass |=>
        mem_req && !mem_half && mem_addr == $past(tb_base) + $past(rf_data_b))
        else $error("byte table address wrong");
    tb_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_reg == CBC_TB_WAIT && mem_ack && mem_half |=> ##1
        branch_valid && branch_target == $past(hold_reg.addr, 2) + CBC_TB_LEN
        + {15'h0, $past(mem_rdata, 2), 1'b0})
        else $error("half table target wrong");
    it_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && !exc_return && in_block && it_reg.mask[2:0] == 3'h0 |=> exc_it_state == 8'h00)
        else $error("block state not cleared");
endmodule

// file: rtl/cbc_pkg.sv
// shared types and constants for conditional branch control
package cbc_pkg;
    localparam int unsigned CBC_REG_W   = 4;
    localparam logic [3:0]  CBC_REG_SP  = 4'hD;
    localparam logic [3:0]  CBC_REG_LR  = 4'hE;
    localparam logic [3:0]  CBC_REG_PC  = 4'hF;
    localparam logic [3:0]  CBC_COND_AL = 4'hE;
    localparam logic [31:0] CBC_ZERO    = 32'h0;
    // pc of a 16-bit instruction reads as its address plus 4
    localparam logic [31:0] CBC_PC_AHEAD = 32'h4;
    // table branch is 32 bits long
    localparam logic [31:0] CBC_TB_LEN   = 32'h4;
    localparam logic [3:0]  CBC_IT_MASK_DONE = 4'h8;

    typedef enum logic [2:0] {
        CBC_OP_NONE,
        CBC_OP_CMP_ZERO,
        CBC_OP_CMP_NONZERO,
        CBC_OP_IT,
        CBC_OP_TB_BYTE,
        CBC_OP_TB_HALF,
        CBC_OP_BREAKPOINT_INSTR,
        CBC_OP_OTHER
    } cbc_op_e;

    // decoded instruction from the fetch side
    typedef struct packed {
        logic        valid;
        cbc_op_e     op;
        logic [31:0] addr;
        logic [3:0]  cond;
        logic [3:0]  it_mask;
        logic [3:0]  base_reg;
        logic [3:0]  index_reg;
        logic [6:0]  offset;
    } cbc_instr_s;

    // condition flags n z c v
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cbc_flags_s;

    // if-then state: base condition and remaining switch mask
    typedef struct packed {
        logic [3:0] cond;
        logic [3:0] mask;
    } cbc_it_s;
endpackage

// file: rtl/cbc_cond_eval.sv
// condition code evaluator
`timescale 1ns/1ns
module cbc_cond_eval
    import cbc_pkg::*;
(
    // inputs
    input  wire logic [3:0] cond,
    input  wire cbc_flags_s flags,
    // result
    output logic            pass
);
    logic base;
    always_comb begin
        unique case (cond[3:1])
            3'h0:    base = flags.z;
            3'h1:    base = flags.c;
            3'h2:    base = flags.n;
            3'h3:    base = flags.v;
            3'h4:    base = flags.c & ~flags.z;
            3'h5:    base = (flags.n == flags.v);
            3'h6:    base = (flags.n == flags.v) & ~flags.z;
            default: base = 1'b1;
        endcase
        if (cond[3:1] == 3'h7) begin
            pass = 1'b1;
        end else begin
            pass = base ^ cond[0];
        end
    end
endmodule

// file: bench/cbc_prog_mem.sv
// program memory model: instruction feed and table reads
`timescale 1ns/1ns
module cbc_prog_mem
    import cbc_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // instruction stream
    output cbc_instr_s       instr,
    input  wire logic        instr_ready,
    // table read port
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic        mem_half,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [7:0] bytes [logic [31:0]];
    int         ack_wait = 0;
    initial begin
        instr     = '0;
        mem_ack   = 1'b0;
        mem_rdata = 16'h0;
    end
    // held until taken; returns one step after the taking edge, for a table branch too; the next send waits for the return to idle
    task automatic send(input cbc_instr_s i);
        instr = i;
        do @(posedge clk_sys); while (instr_ready !== 1'b1);
        #1;
    endtask
    // released stream shows no stale fields
    task automatic idle();
        instr = {1'b0, ~instr[$bits(cbc_instr_s)-2:0]};
    endtask
    initial forever begin
        @(posedge clk_sys);
        if (mem_req === 1'b1) begin
            repeat (ack_wait) @(posedge clk_sys);
            #1;
            mem_ack   = 1'b1;
            mem_rdata = mem_half ? {bytes[mem_addr + 32'h1], bytes[mem_addr]}
                                 : {~bytes[mem_addr], bytes[mem_addr]};
            @(posedge clk_sys);
            #1;
            mem_ack   = 1'b0;
            mem_rdata = ~mem_rdata;
        end
    end
endmodule

// file: bench/tb.sv
// self-checking bench for conditional branch control
`timescale 1ns/1ns
module tb
    import cbc_pkg::*;
;
    typedef struct packed {
        logic        br;
        logic [31:0] tgt;
        logic        bk;
        logic        fh;
    } cbc_note_s;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        exc_entry = 1'b0, exc_return = 1'b0;
    logic        instr_ready, mem_req, mem_half, mem_ack;
    logic        branch_valid, exec_en, breakpoint_instr_hit, flags_hold;
    logic [3:0]  rf_addr_a, rf_addr_b;
    logic [31:0] rf_data_a, rf_data_b, mem_addr, branch_target;
    logic [31:0] pc = 32'h100;
    logic [15:0] mem_rdata;
    logic [7:0]  exc_it_state, it_st = 8'h0, exc_ret_it_state = 8'h0;
    cbc_instr_s  instr;
    cbc_flags_s  flags = '0;
    logic [31:0] regs [16];
    cbc_note_s   notes [$];
    cbc_note_s   nt;
    int          miscompares = 0, samples_checked = 0, cycles = 0;

    assign rf_data_a = regs[rf_addr_a];
    assign rf_data_b = regs[rf_addr_b];
    initial forever #5 clk_sys = ~clk_sys;

    cbc_branch_ctrl cbc_branch_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr(instr),
        .instr_ready(instr_ready), .rf_addr_a(rf_addr_a), .rf_addr_b(rf_addr_b),
        .rf_data_a(rf_data_a), .rf_data_b(rf_data_b), .flags(flags), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_half(mem_half), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .exc_entry(exc_entry), .exc_it_state(exc_it_state), .exc_return(exc_return),
        .exc_ret_it_state(exc_ret_it_state), .branch_valid(branch_valid),
        .branch_target(branch_target), .exec_en(exec_en), .breakpoint_instr_hit(breakpoint_instr_hit),
        .flags_hold(flags_hold));
    cbc_prog_mem cbc_prog_mem_i (.clk_sys(clk_sys), .instr(instr), .instr_ready(instr_ready),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_half(mem_half), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic passes(input logic [3:0] c);
        logic r;
        case (c[3:1])
            3'h0: r = flags.z;
            3'h1: r = flags.c;
            3'h2: r = flags.n;
            3'h3: r = flags.v;
            3'h4: r = flags.c & ~flags.z;
            3'h5: r = flags.n ~^ flags.v;
            3'h6: r = ~flags.z & (flags.n ~^ flags.v);
            default: r = 1'b1;
        endcase
        return c[0] ? ~r : r;
    endfunction

    function automatic logic [3:0] it_mask(input logic [3:0] b, input int n, input logic [2:0] e);
        logic [3:0] m;
        m = 4'h8 >> (n - 1);
        for (int k = 2; k <= n; k++) m[5-k] = b[0] ^ e[k-2];
        return m;
    endfunction

    // note the expected result, then hand the instruction to the stream
    task automatic run(input cbc_op_e op, input logic [3:0] c, input logic [3:0] ra,
                       input logic [3:0] rb, input logic [6:0] off, input logic [3:0] msk);
        cbc_instr_s  i;
        logic [31:0] a;
        logic [15:0] e;
        i = '{1'b1, op, pc, (it_st != 8'h0) ? it_st[7:4] : c, msk, ra, rb, off};
        case (op)
            CBC_OP_CMP_ZERO, CBC_OP_CMP_NONZERO: notes.push_back('{(regs[ra] == CBC_ZERO) ^
                (op == CBC_OP_CMP_NONZERO), pc + CBC_PC_AHEAD + {24'h0, off, 1'b0}, 1'b0, 1'b1});
            CBC_OP_IT: notes.push_back('{1'b0, 32'h0, 1'b0, 1'b1});
            CBC_OP_BREAKPOINT_INSTR: notes.push_back('{1'b0, 32'h0, 1'b1, 1'b0});
            CBC_OP_OTHER: if (passes(i.cond)) notes.push_back('{1'b0, 32'h0, 1'b0, 1'b0});
            default: if (passes(i.cond)) begin
                a = (ra == CBC_REG_PC) ? pc + CBC_TB_LEN : regs[ra];
                a += (op == CBC_OP_TB_HALF) ? {regs[rb][30:0], 1'b0} : regs[rb];
                if (!cbc_prog_mem_i.bytes.exists(a))
                    cbc_prog_mem_i.bytes[a] = 8'($urandom);
                if (!cbc_prog_mem_i.bytes.exists(a + 32'h1))
                    cbc_prog_mem_i.bytes[a + 32'h1] = 8'($urandom);
                e = {(op == CBC_OP_TB_HALF) ? cbc_prog_mem_i.bytes[a + 32'h1] : 8'h00,
                     cbc_prog_mem_i.bytes[a]};
                // accepted table branch reports once at issue, then with its target
                notes.push_back('{1'b0, 32'h0, 1'b0, 1'b1});
                notes.push_back('{1'b1, pc + CBC_TB_LEN + {15'h0, e, 1'b0}, 1'b0, 1'b1});
            end
        endcase
        if (op == CBC_OP_IT) it_st = {i.cond, msk};
        else if (it_st[2:0] == 3'h0) it_st = 8'h0;
        else it_st[4:0] = it_st[4:0] << 1;
        cbc_prog_mem_i.send(i);
        pc += (op inside {CBC_OP_TB_BYTE, CBC_OP_TB_HALF}) ? 32'h4 : 32'h2;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // results in issue order against the oldest note
    always @(negedge clk_sys) begin
        if (!sys_rst && (branch_valid | exec_en | breakpoint_instr_hit) === 1'b1) begin
            if (notes.size() == 0) check("unexpected result", 32'h0, 32'h1);
            else begin
                nt = notes.pop_front();
                check("branch_valid", nt.br, branch_valid);
                check("exec_en", 32'h1, exec_en);
                check("breakpoint_instr_hit", nt.bk, breakpoint_instr_hit);
                if (nt.br) check("branch_target", nt.tgt, branch_target);
                if (nt.fh) check("flags_hold", 32'h1, flags_hold);
            end
        end
    end

    initial begin
        logic [3:0] r;
        logic [2:0] e;
        int         n;
        foreach (regs[k]) regs[k] = 32'h0;
        void'($urandom(31));
        repeat (20) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        for (int k = 0; k < 16; k++) begin
            r = 4'($urandom_range(7));
            regs[r] = k[1] ? CBC_ZERO : ($urandom | 32'h1);
            run(k[0] ? CBC_OP_CMP_NONZERO : CBC_OP_CMP_ZERO, CBC_COND_AL, r, 4'h0, k[2] ? 7'h3F :
                k[3] ? 7'($urandom_range(63)) : 7'h00, 4'h0);
        end
        cbc_prog_mem_i.idle();
        $display("test compare_branch done");
        for (int c = 0; c < 15; c++) begin
            flags = 4'($urandom);
            n = c % 4 + 1;
            e = (c == 14) ? 3'h0 : 3'($urandom);
            run(CBC_OP_IT, 4'(c), 4'h0, 4'h0, 7'h0, it_mask(4'(c), n, e));
            for (int s = 1; s <= n; s++)
                run((s == n && c[0]) ? CBC_OP_BREAKPOINT_INSTR : CBC_OP_OTHER, CBC_COND_AL, 4'h0, 4'h0, 7'h0,
                    4'h0);
            run(CBC_OP_OTHER, CBC_COND_AL, 4'h0, 4'h0, 7'h0, 4'h0);
        end
        cbc_prog_mem_i.idle();
        $display("test if_then done");
        foreach (regs[k]) regs[k] = 32'($urandom_range(255));
        regs[15] = 32'hFFFF_FFF0;
        for (int k = 0; k < 8; k++) begin
            cbc_prog_mem_i.ack_wait = k[1] ? 3 : 0;
            if (k > 3) begin
                flags = 4'($urandom);
                run(CBC_OP_IT, 4'($urandom_range(13)), 4'h0, 4'h0, 7'h0, 4'h8);
            end
            run(k[0] ? CBC_OP_TB_HALF : CBC_OP_TB_BYTE, CBC_COND_AL, (k % 3 == 2) ? CBC_REG_PC :
                4'(k), 4'(k + 5), 7'h0, 4'h0);
        end
        cbc_prog_mem_i.idle();
        $display("test table_branch done");
        flags = 4'($urandom);
        r = 4'($urandom_range(13));
        run(CBC_OP_IT, r, 4'h0, 4'h0, 7'h0, it_mask(r, 4, 3'($urandom)));
        repeat (2) run(CBC_OP_OTHER, CBC_COND_AL, 4'h0, 4'h0, 7'h0, 4'h0);
        cbc_prog_mem_i.idle();
        @(posedge clk_sys);
        #1;
        check("exc_it_state", it_st, exc_it_state);
        exc_entry = 1'b1;
        @(posedge clk_sys);
        #1;
        exc_entry = 1'b0;
        it_st = {4'($urandom_range(13)), 1'($urandom), 3'h4};
        exc_ret_it_state = it_st;
        exc_return = 1'b1;
        @(posedge clk_sys);
        #1;
        exc_return = 1'b0;
        exc_ret_it_state = ~exc_ret_it_state;
        repeat (3) run(CBC_OP_OTHER, CBC_COND_AL, 4'h0, 4'h0, 7'h0, 4'h0);
        cbc_prog_mem_i.idle();
        repeat (10) @(posedge clk_sys);
        $display("test exception done");
        check("pending results", 32'h0, notes.size());
        complete_run();
    end
endmodule
